// file: verilog/adcs_map.svh
// Register offsets, field positions, reset values and timing counts of the conversion sequencer
// Behaviour
// - Successive approximation yields unsigned 8-bit result
// - Conversion starts only by writing start one
// - Start flag reads one until conversion ends
// - Completion sets conversion-done request bit
// - Interrupt raised only while enable is one
// - Result loads same cycle flag clears, then idle
// - Each start flag write while idle reconverts; a start write during a conversion is ignored
// - Writing zero stops; other bits read one
// - Port mode register write-only, resets zero
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH
// Byte addresses on the register bus
`define ADCS_OFF_MODE 8'h00
`define ADCS_OFF_START 8'h04
`define ADCS_OFF_RESULT 8'h08
`define ADCS_OFF_PORT0 8'h0C
`define ADCS_OFF_IRQ_REQ 8'h10
`define ADCS_OFF_IRQ_EN 8'h14
// Field positions
`define ADCS_BIT_START 7
`define ADCS_BIT_DONE 0
// Reset and fixed values
`define ADCS_RST_MODE 8'h00
`define ADCS_RST_PORT0 8'h00
`define ADCS_START_RSVD 7'h7F
// Cycles spent sampling the input before the bit trials
`define ADCS_SAMPLE_CYCLES 4
// Cycles each trial code is held so the synchronised comparator settles
`define ADCS_SETTLE_CYCLES 6
`endif

// file: verilog/adcs_pkg.sv
// Types shared by the conversion sequencer files
package adcs_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0]
  {
    ADCS_IDLE = 3'b001,
    ADCS_SAMPLE = 3'b010,
    ADCS_TRIAL = 3'b100
  } adcs_state_t;
endpackage : adcs_pkg

// file: verilog/adcs_sar.sv
// Successive-approximation bit trial register
module adcs_sar #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic step,
  input wire logic comp_above,
  output logic [WIDTH-1:0] trial,
  output logic last
);
  logic [WIDTH-1:0] trial_ff;
  logic [WIDTH-1:0] mark_ff;
  logic [WIDTH-1:0] nxt_trial;
  logic [WIDTH-1:0] nxt_mark;

  ////////////////////////////////////////////////////////////////
  // Per-bit trial: keep or drop marked bit, set next one
  always_comb
  begin
    nxt_trial = trial_ff;
    nxt_mark = mark_ff;
    if (load)
    begin
      nxt_mark = {1'b1, {(WIDTH-1){1'b0}}};
      nxt_trial = {1'b1, {(WIDTH-1){1'b0}}};
    end
    else if (step)
    begin
      nxt_mark = mark_ff >> 1;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (mark_ff[i])
        begin
          // Drop bit if trial overshoots input
          nxt_trial[i] = ~comp_above ? 1'b0 : 1'b1;
          if (i > 0)
          begin
            nxt_trial[i-1] = 1'b1;
          end
        end
      end
    end
  end

  // Register stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trial_ff <= '0;
      mark_ff <= '0;
    end
    else
    begin
      trial_ff <= nxt_trial;
      mark_ff <= nxt_mark;
    end
  end

  assign trial = trial_ff;
  assign last = ~|mark_ff; // All bits decided once the mark shifts out
endmodule : adcs_sar

// file: verilog/adcs_sync.sv
// Two-flop synchroniser for the comparator level
module adcs_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;

  // Two stages, first read only by second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule : adcs_sync

// file: verilog/adcs_top.sv
// AXI4-Lite conversion sequencer top with registers and interrupt
`include "adcs_map.svh"
module adcs_top #(
  parameter int WIDTH = 8,
  parameter int SAMPLE_CYCLES = `ADCS_SAMPLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comp_above,
  output logic [WIDTH-1:0] dac_trial,
  output logic sampling,
  output logic [7:0] converter_mode,
  output logic [7:0] port_zero_mode,
  output logic irq
);
  // Bus write capture and read response
  logic aw_hold_ff, nxt_aw_hold;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic w_hold_ff, nxt_w_hold;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  // Channel readies, kept in flops so outputs need no gate
  logic awready_ff, wready_ff, arready_ff;
  // Register state
  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] port0_ff, nxt_port0;
  logic [WIDTH-1:0] result_ff, nxt_result;
  logic done_req_ff, nxt_done_req;
  logic done_en_ff, nxt_done_en;
  logic irq_ff, nxt_irq;
  // Sequencer state
  adcs_pkg::adcs_state_t state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt; // Sample and settle wait
  // Trial code held this long before the comparator is trusted
  localparam int SETTLE_CYCLES = `ADCS_SETTLE_CYCLES;
  // Internal strobes
  logic wr_fire, wr_byte0, start_wr, stop_wr;
  logic sar_load, sar_step, sar_last;
  logic [WIDTH-1:0] sar_trial;
  logic comp_sync;
  logic busy, complete;
  logic sample_ff, nxt_sample;
  logic [WIDTH-1:0] dac_ff;

  ////////////////////////////////////////////////////////////////
  // Comparator from analog side, synchronised
  adcs_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(comp_above),
    .dout(comp_sync)
  );

  // Bit trial engine
  adcs_sar #(.WIDTH(WIDTH)) u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(sar_load),
    .step(sar_step),
    .comp_above(comp_sync),
    .trial(sar_trial),
    .last(sar_last)
  );

  ////////////////////////////////////////////////////////////////
  // Write decode: both halves held, response free
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_byte0 = wr_fire && w_strb_ff[0];
  assign start_wr = wr_byte0 && (aw_addr_ff == `ADCS_OFF_START) && w_data_ff[`ADCS_BIT_START];
  assign stop_wr = wr_byte0 && (aw_addr_ff == `ADCS_OFF_START) && !w_data_ff[`ADCS_BIT_START];
  assign busy = (state_ff != adcs_pkg::ADCS_IDLE);
  assign complete = (state_ff == adcs_pkg::ADCS_TRIAL) && sar_last && !stop_wr;

  // Bus channel next values
  always_comb
  begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    // Take address and data in either order
    if (!aw_hold_ff && s_axi_awvalid)
    begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (!w_hold_ff && s_axi_wvalid)
    begin
      nxt_w_hold = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    // Response after both halves
    if (wr_fire)
    begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      case (aw_addr_ff)
        `ADCS_OFF_MODE, `ADCS_OFF_START, `ADCS_OFF_RESULT, `ADCS_OFF_PORT0, `ADCS_OFF_IRQ_REQ, `ADCS_OFF_IRQ_EN:
          nxt_bresp = 2'b00;
        default:
          nxt_bresp = 2'b10;
      endcase
    end
    else if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    // Read: one cycle to data
    if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
    end
    else if (!rvalid_ff && s_axi_arvalid)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = 2'b00;
      case ({s_axi_araddr[7:2], 2'b00})
        `ADCS_OFF_MODE:
          nxt_rdata = {24'h000000, mode_ff};
        `ADCS_OFF_START:
          nxt_rdata = {24'h000000, busy, `ADCS_START_RSVD};
        `ADCS_OFF_RESULT:
          nxt_rdata = {{(32-WIDTH){1'b0}}, result_ff};
        `ADCS_OFF_PORT0:
          nxt_rdata = 32'h00000000;
        `ADCS_OFF_IRQ_REQ:
          nxt_rdata = {31'h00000000, done_req_ff};
        `ADCS_OFF_IRQ_EN:
          nxt_rdata = {31'h00000000, done_en_ff};
        default:
        begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = 2'b10;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register file next values
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_port0 = port0_ff;
    nxt_done_en = done_en_ff;
    nxt_done_req = done_req_ff;
    nxt_result = result_ff;
    if (wr_byte0 && aw_addr_ff == `ADCS_OFF_MODE)
    begin
      nxt_mode = w_data_ff[7:0];
    end
    if (wr_byte0 && aw_addr_ff == `ADCS_OFF_PORT0)
    begin
      nxt_port0 = w_data_ff[7:0];
    end
    if (wr_byte0 && aw_addr_ff == `ADCS_OFF_IRQ_EN)
    begin
      nxt_done_en = w_data_ff[`ADCS_BIT_DONE];
    end
    // Write one clears the request
    if (wr_byte0 && aw_addr_ff == `ADCS_OFF_IRQ_REQ && w_data_ff[`ADCS_BIT_DONE])
    begin
      nxt_done_req = 1'b0;
    end
    // Completion wins over a clear
    if (complete)
    begin
      nxt_done_req = 1'b1;
      nxt_result = sar_trial;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    sar_load = 1'b0;
    sar_step = 1'b0;
    case (state_ff)
      adcs_pkg::ADCS_IDLE:
      begin
        // Fresh conversion on each start write
        if (start_wr)
        begin
          nxt_state = adcs_pkg::ADCS_SAMPLE;
          nxt_cnt = 8'(SAMPLE_CYCLES - 1);
        end
      end
      adcs_pkg::ADCS_SAMPLE:
      begin
        if (stop_wr)
        begin
          nxt_state = adcs_pkg::ADCS_IDLE;
        end
        else if (cnt_ff == 8'h00)
        begin
          nxt_state = adcs_pkg::ADCS_TRIAL;
          sar_load = 1'b1;
          nxt_cnt = 8'(SETTLE_CYCLES - 1);
        end
        else
        begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      adcs_pkg::ADCS_TRIAL:
      begin
        if (stop_wr)
        begin
          nxt_state = adcs_pkg::ADCS_IDLE;
        end
        else if (sar_last)
        begin
          nxt_state = adcs_pkg::ADCS_IDLE;
        end
        else if (cnt_ff == 8'h00)
        begin
          // Comparator settled: decide bit, restart the wait
          sar_step = 1'b1;
          nxt_cnt = 8'(SETTLE_CYCLES - 1);
        end
        else
        begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default:
        nxt_state = adcs_pkg::ADCS_IDLE;
    endcase
    nxt_sample = (nxt_state == adcs_pkg::ADCS_SAMPLE);
    nxt_irq = nxt_done_req && nxt_done_en;
  end

  ////////////////////////////////////////////////////////////////
  // All state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'b00;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
      mode_ff <= `ADCS_RST_MODE;
      port0_ff <= `ADCS_RST_PORT0;
      result_ff <= '0;
      done_req_ff <= 1'b0;
      done_en_ff <= 1'b0;
      irq_ff <= 1'b0;
      state_ff <= adcs_pkg::ADCS_IDLE;
      cnt_ff <= 8'h00;
      sample_ff <= 1'b0;
      dac_ff <= '0;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff <= nxt_w_hold;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      awready_ff <= !nxt_aw_hold;
      wready_ff <= !nxt_w_hold;
      arready_ff <= !nxt_rvalid;
      mode_ff <= nxt_mode;
      port0_ff <= nxt_port0;
      result_ff <= nxt_result;
      done_req_ff <= nxt_done_req;
      done_en_ff <= nxt_done_en;
      irq_ff <= nxt_irq;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sample_ff <= nxt_sample;
      dac_ff <= sar_trial;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign converter_mode = mode_ff;
  assign port_zero_mode = port0_ff;
  assign dac_trial = dac_ff;
  assign sampling = sample_ff;
  assign irq = irq_ff;
endmodule : adcs_top

// file: verification/adcs_chk.sv
// Checker for bus handshakes, sample phase and reset state of the sequencer top
module adcs_chk #(
  parameter int WIDTH = 8,
  parameter int SAMPLE_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sampling,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // Sample phase of fixed length, then trials
  sequence s_sample;
    sampling [*4] ##1 !sampling;
  endsequence
  // Sampling entered only near a register write
  sequence s_wrote;
    s_axi_bvalid || $past(s_axi_bvalid);
  endsequence
  a_sample_len: assert property ($rose(sampling) |-> s_sample)
    else $error("sample phase length wrong");
  a_start_cause: assert property ($rose(sampling) |-> s_wrote)
    else $error("conversion began without a write");
  a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !irq && !sampling && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  ////////////////////////////////////////////////////////////
  // Register bus answers
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_rdata_pad: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule : adcs_chk
bind adcs_top adcs_chk #(.WIDTH(WIDTH), .SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sampling, .irq);

// file: verification/testbench.sv
// Self-checking bench for the conversion sequencer over AXI4-Lite
`include "adcs_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, comp_above;
  logic sampling, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dac_trial, converter_mode, port_zero_mode;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [7:0] vin; // Analog level seen by the comparator
  int err_count, checks;
  adcs_top #(.WIDTH(8), .SAMPLE_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp_above, .dac_trial, .sampling,
    .converter_mode, .port_zero_mode, .irq);
  ////////////////////////////////////////////////////////////
  // Clock and comparator model
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) comp_above <= (vin >= dac_trial);
  ////////////////////////////////////////////////////////////
  // Verdict and comparison
  task end_sim;
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task tmo(input logic hit);
    if (hit)
    begin
      err_count++;
      end_sim();
    end
  endtask : tmo
  ////////////////////////////////////////////////////////////
  // Bus cycles; ready for the answer comes late on purpose
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (n == 4)
        s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 60);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n >= 60);
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (n == 3)
        s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 60);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n >= 60);
  endtask : rd
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, rv);
  endtask : rdchk
  // Clear request, set enable, start, poll the flag until it drops
  task conv(input logic [7:0] v, input logic [31:0] en);
    int k;
    vin <= v;
    wr(`ADCS_OFF_IRQ_REQ, 32'h1);
    wr(`ADCS_OFF_IRQ_EN, en);
    wr(`ADCS_OFF_START, 32'h80);
    rdchk(`ADCS_OFF_START, 32'hFF, "start busy");
    k = 0;
    do
    begin
      rd(`ADCS_OFF_START);
      k++;
    end
    while (rv[7] !== 1'b0 && k < 40);
    tmo(k >= 40);
  endtask : conv
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, vin} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`ADCS_OFF_START, 32'h7F, "start reset");
    rdchk(`ADCS_OFF_IRQ_REQ, 32'h0, "req reset");
    chk("irq reset", 32'h0, {31'h0, irq});
    wr(`ADCS_OFF_PORT0, 32'h02);
    chk("port0 out", 32'h02, {24'h0, port_zero_mode});
    rdchk(`ADCS_OFF_PORT0, 32'h0, "port0 read");
    wr(`ADCS_OFF_MODE, 32'h05);
    chk("mode wresp", 32'h0, {30'h0, br});
    rdchk(`ADCS_OFF_MODE, 32'h05, "mode read");
    chk("mode out", 32'h05, {24'h0, converter_mode});
    rd(8'h1C);
    chk("unmapped resp", 32'h2, {30'h0, rr});
    wr(8'h1C, 32'h0);
    chk("unmapped wresp", 32'h2, {30'h0, br});
    conv(8'hA5, 32'h1);
    rdchk(`ADCS_OFF_RESULT, 32'hA5, "result");
    rdchk(`ADCS_OFF_IRQ_REQ, 32'h1, "req done");
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`ADCS_OFF_RESULT, 32'h0);
    rdchk(`ADCS_OFF_RESULT, 32'hA5, "result ro");
    conv(8'h3C, 32'h0);
    rdchk(`ADCS_OFF_RESULT, 32'h3C, "result again");
    rdchk(`ADCS_OFF_IRQ_REQ, 32'h1, "req masked");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`ADCS_OFF_IRQ_EN, 32'h1);
    rdchk(`ADCS_OFF_IRQ_REQ, 32'h1, "req kept");
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`ADCS_OFF_IRQ_REQ, 32'h1);
    rdchk(`ADCS_OFF_IRQ_REQ, 32'h0, "req cleared");
    chk("irq cleared", 32'h0, {31'h0, irq});
    vin <= 8'h11;
    wr(`ADCS_OFF_START, 32'h80);
    wr(`ADCS_OFF_START, 32'h00);
    rdchk(`ADCS_OFF_START, 32'h7F, "start stopped");
    repeat (20) @(posedge aclk);
    rdchk(`ADCS_OFF_RESULT, 32'h3C, "result kept");
    rdchk(`ADCS_OFF_IRQ_REQ, 32'h0, "req after stop");
    end_sim();
  end
endmodule : testbench
